/* dcs_clock_select.sv */
// Purpose: clock divisor selection for main and subsystem oscillators
// Assumes: oscillators arrive as one-cycle enables OSC_TICK and X_TICK
// Notes:   all clock outputs are one-cycle enable pulses on CLK
// Function
// - select one is 4-bit write-only; divisor and range bits clear on reset, stop
// - stop bit changes only on reset or a select one write, not on stop entry; when set, subsystem oscillator halts in stop
// - divisor bit zero gives subsystem clock divided by 8, one gives by 4
// - watch prescaler clock is always subsystem oscillator divided by eight
// - select two is 2-bit write-only; clears on reset and stop entry
// - main divisor codes 00..11 divide by 4, 8, 16, 32; reset 00
// - written main divisor waits; old divisor runs until active is entered again
// - written in active, applies on return to active after watch
// - written in subactive, applies on entering active by any path except through stop, whose entry clears it
// - low-speed flag picks main or subsystem source at mode transitions
// - CPU and peripheral clocks are equal: main divider tick in active, subsystem divider tick in subactive, none otherwise
`timescale 1ns/10ps
`include "dcs_consts.svh"
module dcs_clock_select (
    input  wire logic                   CLK,
    input  wire logic                   RST_N,
    input  wire logic [1:0]             MODE,
    input  wire logic                   OSC_TICK,
    input  wire logic                   X_TICK,
    input  wire logic                   WR_EN,
    input  wire logic [`DCS_ADDR_W-1:0] WR_ADDR,
    input  wire logic [3:0]             WR_DATA,
    input  wire logic                   BIT_WR,
    input  wire logic [`DCS_ADDR_W-1:0] BIT_ADDR,
    input  wire logic [1:0]             BIT_POS,
    input  wire logic                   BIT_VAL,
    output logic                        LOW_SPD_Q,
    output logic                        SRC_SUB,
    output logic                        CPU_TICK,
    output logic                        PER_TICK,
    output logic                        W_TICK,
    output logic                        SUB_OSC_RUN,
    output logic                        RANGE_HI
);
    dcs_pkg::dcs_mode_e mode;
    dcs_pkg::dcs_mode_e mode_reg;
    dcs_pkg::dcs_mode_e mode_next;
    logic [3:0]         sel1_reg;
    logic [3:0]         sel1_next;
    dcs_pkg::dcs_div_t  sel2_reg;
    dcs_pkg::dcs_div_t  sel2_next;
    dcs_pkg::dcs_div_t  act_div_reg;
    dcs_pkg::dcs_div_t  act_div_next;
    logic               low_spd_reg;
    logic               low_spd_next;
    logic               src_reg;
    logic               src_next;
    logic               cpu_reg;
    logic               cpu_next;
    logic               w_reg;
    logic               w_next;
    logic               run_reg;
    logic               run_next;
    logic               stop_entry;
    logic               x_en;
    logic [5:0]         main_div;

    dcs_div_if #(.W(5)) main_if ();
    dcs_div_if #(.W(3)) sub_if ();
    dcs_div_if #(.W(3)) w_if ();

    assign mode       = dcs_pkg::dcs_mode_e'(MODE);
    assign stop_entry = (mode == dcs_pkg::DCS_STOP) && (mode_reg != dcs_pkg::DCS_STOP);
    assign x_en       = X_TICK && run_reg;
    assign main_div   = `DCS_MAIN_BASE << act_div_reg;

    assign main_if.en   = OSC_TICK;
    assign main_if.term = 5'(main_div - 6'h01);
    assign sub_if.en    = x_en;
    assign sub_if.term  = sel1_reg[`DCS_SEL1_SUBDIV] ? `DCS_SUB_TERM_4 : `DCS_SUB_TERM_8;
    assign w_if.en      = x_en;
    assign w_if.term    = `DCS_W_TERM;

    dcs_tick_div #(.W(5)) u_main (.CLK(CLK), .RST_N(RST_N), .port_d(main_if.div));
    dcs_tick_div #(.W(3)) u_sub  (.CLK(CLK), .RST_N(RST_N), .port_d(sub_if.div));
    dcs_tick_div #(.W(3)) u_w    (.CLK(CLK), .RST_N(RST_N), .port_d(w_if.div));

    always_comb begin
        mode_next    = mode;
        sel1_next    = sel1_reg;
        sel2_next    = sel2_reg;
        act_div_next = act_div_reg;
        low_spd_next = low_spd_reg;
        src_next     = src_reg;
        if (WR_EN && WR_ADDR == `DCS_ADDR_SEL1) begin
            sel1_next = WR_DATA;
        end
        if (WR_EN && WR_ADDR == `DCS_ADDR_SEL2) begin
            sel2_next = WR_DATA[1:0];
        end
        if (BIT_WR && BIT_ADDR == `DCS_ADDR_LOW_SPD && BIT_POS == `DCS_LOW_SPD_BIT) begin
            low_spd_next = BIT_VAL;
        end
        // stop entry overrides a write in the same cycle; stop bit survives
        if (stop_entry) begin
            sel1_next[`DCS_SEL1_SUBDIV] = 1'b0;
            sel1_next[`DCS_SEL1_RANGE]  = 1'b0;
            sel2_next                   = `DCS_SEL2_RESET;
        end
        // pending divisor reaches the divider only on entry to active
        if (mode == dcs_pkg::DCS_ACTIVE && mode_reg != dcs_pkg::DCS_ACTIVE) begin
            act_div_next = sel2_reg;
        end
        if (mode != mode_reg) begin
            src_next = low_spd_reg;
        end
        cpu_next = 1'b0;
        if (mode == dcs_pkg::DCS_ACTIVE) begin
            cpu_next = main_if.tick;
        end else if (mode == dcs_pkg::DCS_SUBACTIVE) begin
            cpu_next = sub_if.tick;
        end
        w_next   = w_if.tick;
        run_next = !(mode == dcs_pkg::DCS_STOP && sel1_reg[`DCS_SEL1_STOP]);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_reg    <= dcs_pkg::DCS_ACTIVE;
            sel1_reg    <= `DCS_SEL1_RESET;
            sel2_reg    <= `DCS_SEL2_RESET;
            act_div_reg <= `DCS_SEL2_RESET;
            low_spd_reg <= 1'b0;
            src_reg     <= 1'b0;
            cpu_reg     <= 1'b0;
            w_reg       <= 1'b0;
            run_reg     <= 1'b1;
        end else begin
            mode_reg    <= mode_next;
            sel1_reg    <= sel1_next;
            sel2_reg    <= sel2_next;
            act_div_reg <= act_div_next;
            low_spd_reg <= low_spd_next;
            src_reg     <= src_next;
            cpu_reg     <= cpu_next;
            w_reg       <= w_next;
            run_reg     <= run_next;
        end
    end

    assign LOW_SPD_Q   = low_spd_reg;
    assign SRC_SUB     = src_reg;
    assign CPU_TICK    = cpu_reg;
    assign PER_TICK    = cpu_reg;
    assign W_TICK      = w_reg;
    assign SUB_OSC_RUN = run_reg;
    assign RANGE_HI    = sel1_reg[`DCS_SEL1_RANGE];

    stop_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        stop_entry |=> (sel2_reg == 2'h0) && !sel1_reg[2] && !sel1_reg[1])
        else $error("stop entry did not clear selection bits");
    stop_bit_keep_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (stop_entry && !(WR_EN && WR_ADDR == `DCS_ADDR_SEL1))
        |=> sel1_reg[3] == $past(sel1_reg[3]))
        else $error("stop bit changed on stop entry");
    osc_halt_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == dcs_pkg::DCS_STOP && sel1_reg[3]) |=> !SUB_OSC_RUN)
        else $error("subsystem oscillator ran in stop with stop bit set");
    sub_term_a: assert property (@(posedge CLK) disable iff (!RST_N)
        sub_if.term == (sel1_reg[2] ? 3'h3 : 3'h7))
        else $error("subsystem divisor mismatch");
    w_fixed_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(sel1_reg[2]) |-> w_if.term == 3'h7)
        else $error("watch prescaler divisor moved");
    main_term_a: assert property (@(posedge CLK) disable iff (!RST_N)
        main_if.term == 5'((6'h04 << act_div_reg) - 6'h01))
        else $error("main divisor terminal count wrong");
    div_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == dcs_pkg::DCS_ACTIVE && mode_reg == dcs_pkg::DCS_ACTIVE)
        |=> $stable(act_div_reg))
        else $error("divisor changed without leaving active");
    div_apply_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == dcs_pkg::DCS_ACTIVE && mode_reg != dcs_pkg::DCS_ACTIVE)
        |=> act_div_reg == $past(sel2_reg))
        else $error("pending divisor not applied on entering active");
    src_pick_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode != mode_reg) |=> SRC_SUB == $past(low_spd_reg))
        else $error("source not taken from low-speed flag at transition");
    idle_tick_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == dcs_pkg::DCS_WATCH || mode == dcs_pkg::DCS_STOP) |=> !CPU_TICK && !PER_TICK)
        else $error("cpu clock ran in watch or stop");
    // write paths, tick routing and hold checks
    sel1_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR_EN && WR_ADDR == `DCS_ADDR_SEL1 && !stop_entry) |=> sel1_reg == $past(WR_DATA))
        else $error("select one write not stored");
    sel2_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (WR_EN && WR_ADDR == `DCS_ADDR_SEL2 && !stop_entry) |=> sel2_reg == $past(WR_DATA[1:0]))
        else $error("select two write not stored");
    flag_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (BIT_WR && BIT_ADDR == `DCS_ADDR_LOW_SPD && BIT_POS == `DCS_LOW_SPD_BIT)
        |=> LOW_SPD_Q == $past(BIT_VAL))
        else $error("low-speed flag bit write not stored");
    main_tick_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == dcs_pkg::DCS_ACTIVE) |=> CPU_TICK == $past(main_if.tick))
        else $error("cpu clock not taken from main divider in active");
    sub_tick_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == dcs_pkg::DCS_SUBACTIVE) |=> CPU_TICK == $past(sub_if.tick))
        else $error("cpu clock not taken from subsystem divider in subactive");
    per_equal_a: assert property (@(posedge CLK) disable iff (!RST_N)
        PER_TICK == CPU_TICK)
        else $error("peripheral clock differs from cpu clock");
    w_tick_a: assert property (@(posedge CLK) disable iff (!RST_N)
        W_TICK == $past(w_if.tick))
        else $error("watch prescaler clock not the fixed divider tick");
    osc_stall_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !SUB_OSC_RUN |-> !sub_if.tick && !w_if.tick)
        else $error("subsystem dividers ran while oscillator halted");
    src_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == mode_reg) |=> $stable(SRC_SUB))
        else $error("source moved without a mode transition");
    stop_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !(WR_EN && WR_ADDR == `DCS_ADDR_SEL1) |=> $stable(sel1_reg[`DCS_SEL1_STOP]))
        else $error("stop bit changed without a write");
    div_idle_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode != dcs_pkg::DCS_ACTIVE) |=> $stable(act_div_reg))
        else $error("divisor changed outside the entry to active");
endmodule

/* dcs_consts.svh */
// Purpose: constants for the dual oscillator clock select block
// Assumes: register addresses are data-memory addresses of the 4-bit core
// Notes:   counts are terminal counts of up-counting dividers that wrap to zero, except DCS_MAIN_BASE, a divisor
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH
`define DCS_ADDR_W        10
`define DCS_ADDR_LOW_SPD  10'h020
`define DCS_LOW_SPD_BIT   2'h0
`define DCS_ADDR_SEL1     10'h027
`define DCS_ADDR_SEL2     10'h028
`define DCS_SEL1_STOP     3
`define DCS_SEL1_SUBDIV   2
`define DCS_SEL1_RANGE    1
`define DCS_SEL1_RESET    4'h0
`define DCS_SEL2_RESET    2'h0
`define DCS_MAIN_BASE     6'h04
`define DCS_SUB_TERM_4    3'h3
`define DCS_SUB_TERM_8    3'h7
`define DCS_W_TERM        3'h7
`endif

/* dcs_pkg.sv */
// Purpose: types for the dual oscillator clock select block
// Assumes: mode codes come from the mode controller
// Notes:   none
package dcs_pkg;
    typedef enum logic [1:0] {
        DCS_ACTIVE    = 2'b00,
        DCS_SUBACTIVE = 2'b01,
        DCS_WATCH     = 2'b10,
        DCS_STOP      = 2'b11
    } dcs_mode_e;
    typedef logic [1:0] dcs_div_t;
endpackage

/* dcs_div_if.sv */
// Purpose: link between the block and one tick divider
// Assumes: one clock domain
// Notes:   none
`timescale 1ns/10ps
interface dcs_div_if #(parameter int W = 5);
    logic         en;
    logic [W-1:0] term;
    logic         tick;
    modport ctl (output en, output term, input tick);
    modport div (input en, input term, output tick);
endinterface

/* dcs_tick_div.sv */
// Purpose: counts input enables and pulses once every term+1 of them
// Assumes: term may change at any time; counter wraps at the new term
// Notes:   tick is a one-cycle pulse coincident with the last enable
`timescale 1ns/10ps
module dcs_tick_div #(parameter int W = 5) (
    input  wire logic CLK,
    input  wire logic RST_N,
    dcs_div_if.div    port_d
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         hit;

    always_comb begin
        hit      = port_d.en && (cnt_reg >= port_d.term);
        cnt_next = cnt_reg;
        if (hit) begin
            cnt_next = '0;
        end else if (port_d.en) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign port_d.tick = hit;
endmodule

/* dcs_clock_select_tb.sv */
// Purpose: self-checking bench for the clock select block
// Assumes: oscillator enables held high, except OSC_TICK in t_gate, so tick periods equal divisors
// Notes:   inputs change by non-blocking assignment at the rising edge
`timescale 1ns/10ps
`include "dcs_consts.svh"
module dcs_clock_select_tb;
    logic       CLK, RST_N, OSC_TICK, X_TICK, WR_EN, BIT_WR, BIT_VAL;
    logic [1:0] MODE, BIT_POS;
    logic [9:0] WR_ADDR, BIT_ADDR;
    logic [3:0] WR_DATA;
    logic       LOW_SPD_Q, SRC_SUB, CPU_TICK, PER_TICK, W_TICK, SUB_OSC_RUN, RANGE_HI;
    int         n_fail, compares, p;
    dcs_clock_select dut (.CLK(CLK), .RST_N(RST_N), .MODE(MODE), .OSC_TICK(OSC_TICK),
        .X_TICK(X_TICK), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
        .BIT_WR(BIT_WR), .BIT_ADDR(BIT_ADDR), .BIT_POS(BIT_POS), .BIT_VAL(BIT_VAL),
        .LOW_SPD_Q(LOW_SPD_Q), .SRC_SUB(SRC_SUB), .CPU_TICK(CPU_TICK), .PER_TICK(PER_TICK),
        .W_TICK(W_TICK), .SUB_OSC_RUN(SUB_OSC_RUN), .RANGE_HI(RANGE_HI));
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [3:0] d);
        @(posedge CLK);
        WR_EN <= 1'b1; WR_ADDR <= a; WR_DATA <= d;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask
    task automatic bw(input logic [1:0] pos, input logic v);
        @(posedge CLK);
        BIT_WR <= 1'b1; BIT_ADDR <= `DCS_ADDR_LOW_SPD; BIT_POS <= pos; BIT_VAL <= v;
        @(posedge CLK);
        BIT_WR <= 1'b0;
    endtask
    task automatic go(input dcs_pkg::dcs_mode_e m);
        @(posedge CLK);
        MODE <= m;
        repeat (4) @(posedge CLK);
    endtask
    // sync to one pulse, then measure the spacing of the following ones
    task automatic period(input bit w, output int q);
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin @(negedge CLK); n++; end
            while (!((w ? W_TICK : CPU_TICK) === 1'b1) && n < 300);
            if (!w) chk("per_tick", PER_TICK, 1'b1);
            q = n;
        end
    endtask
    task automatic t_reset();
        @(negedge CLK);
        chk("reset_outs", {LOW_SPD_Q, SRC_SUB, SUB_OSC_RUN, RANGE_HI}, 4'b0010);
    endtask
    task automatic t_div();
        for (int c = 0; c < 4; c++) begin
            wr(`DCS_ADDR_SEL2, 4'(c));
            period(0, p);
            chk("div_held", p, (c == 0) ? 4 : 4 << (c - 1));
            go(dcs_pkg::DCS_WATCH);
            go(dcs_pkg::DCS_ACTIVE);
            period(0, p);
            chk("div_new", p, 4 << c);
        end
    endtask
    task automatic t_sub();
        go(dcs_pkg::DCS_SUBACTIVE);
        wr(`DCS_ADDR_SEL2, 4'h1);
        period(0, p); chk("sub_div8", p, 8);
        period(1, p); chk("w_div", p, 8);
        go(dcs_pkg::DCS_ACTIVE);
        period(0, p); chk("div_direct", p, 8);
        wr(`DCS_ADDR_SEL1, 4'h4);
        go(dcs_pkg::DCS_SUBACTIVE);
        period(0, p); chk("sub_div4", p, 4);
        period(1, p); chk("w_div_fixed", p, 8);
        go(dcs_pkg::DCS_ACTIVE);
    endtask
    // main enable on every other cycle doubles the cpu tick spacing
    task automatic t_gate();
        fork
            repeat (100) @(posedge CLK) OSC_TICK <= ~OSC_TICK;
            period(0, p);
        join
        @(posedge CLK);
        OSC_TICK <= 1'b1;
        chk("osc_gate", p, 16);
    endtask
    task automatic t_flag();
        bw(2'h1, 1'b1);
        @(negedge CLK); chk("flag_wrong_pos", LOW_SPD_Q, 1'b0);
        bw(2'h0, 1'b1);
        @(negedge CLK); chk("flag_set", LOW_SPD_Q, 1'b1);
        go(dcs_pkg::DCS_WATCH);
        chk("src_sub", SRC_SUB, 1'b1);
        bw(2'h0, 1'b0);
        go(dcs_pkg::DCS_ACTIVE);
        chk("src_main", SRC_SUB, 1'b0);
    endtask
    task automatic t_stop();
        wr(`DCS_ADDR_SEL1, 4'hE);
        wr(10'h029, 4'h0);
        @(negedge CLK); chk("range_set", RANGE_HI, 1'b1);
        go(dcs_pkg::DCS_STOP);
        chk("osc_halt", {SUB_OSC_RUN, RANGE_HI}, 2'b00);
        repeat (16) begin
            @(negedge CLK);
            chk("w_halt", W_TICK, 1'b0);
        end
        go(dcs_pkg::DCS_ACTIVE);
        period(0, p); chk("sel2_clr", p, 4);
        go(dcs_pkg::DCS_SUBACTIVE);
        period(0, p); chk("subdiv_clr", p, 8);
        go(dcs_pkg::DCS_STOP);
        chk("stop_bit_kept", SUB_OSC_RUN, 1'b0);
        go(dcs_pkg::DCS_ACTIVE);
        @(posedge CLK); RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        go(dcs_pkg::DCS_STOP);
        chk("stop_bit_rst", SUB_OSC_RUN, 1'b1);
    endtask
    initial begin
        n_fail = 0; compares = 0; RST_N = 1'b0; MODE = dcs_pkg::DCS_ACTIVE;
        OSC_TICK = 1'b1; X_TICK = 1'b1; WR_EN = 1'b0; WR_ADDR = '0; WR_DATA = '0;
        BIT_WR = 1'b0; BIT_ADDR = '0; BIT_POS = '0; BIT_VAL = 1'b0;
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        t_reset();
        t_div();
        t_sub();
        t_gate();
        t_flag();
        t_stop();
        end_sim();
    end
    initial begin
        #(40 * 20000);
        n_fail++;
        end_sim();
    end
endmodule
